/* File: spm_power_manager.v */
// sleep and idle power manager for a 16-bit signal-controller core
// assumes the core retires power-save with an operand, peripherals honour
// enables, and rstn comes from any device reset source
//
// Summary of operation
// (R1) sleep gates system clock; on-chip oscillator off when in use
// (R2) clock failure monitor disabled throughout sleep
// (R3) low-power rc clock runs in sleep when watchdog enabled
// (R4) watchdog count cleared just before sleep takes effect
// (R5) system-clock peripherals disabled in sleep; external-clock and change-notify kept
// (R6) sleep exits on enabled interrupt, any reset, or watchdog timeout
// (R7) wake from sleep keeps the clock source selected at entry
// (R8) regulators enter standby in sleep when keep-active bits 8 and 11 clear
// (R9) a set keep-active bit keeps its regulator active through sleep
// (R10) core stops fetching and executing while idle
// (R11) watchdog count cleared on entry to idle
// (R12) system clock runs in idle; peripherals run unless individually stopped
// (R13) low-power rc clock runs in idle if watchdog or monitor enabled
// (R14) idle exits on enabled interrupt, any reset, or watchdog timeout
// (R15) core clock restored on idle exit, execution resumes 2 to 4 cycles later; here core clock returns with wake_resume, 3 cycles after leaving idle
// (R16) each peripheral has a stop-in-idle bit; timer one uses bit 13
// (R17) interrupt during power-save entry is deferred, then wakes immediately
// (R18) power-save operand selects sleep or idle, decoded at retire
`timescale 1ns/1ps
`include "spm_consts.vh"
module spm_power_manager
(
  input wire clk,
  input wire rstn,
  input wire power_save_retire,
  input wire power_save_operand,
  input wire irq_pending,
  input wire watchdog_timeout,
  input wire watchdog_timer_enable,
  input wire clock_failure_monitor_enable,
  input wire onchip_osc_selected,
  input wire [2:0] clock_source_select,
  input wire [15:0] reset_control_register,
  input wire [15:0] first_timer_control,
  input wire [`SPM_NPERIPH-1:0] periph_stop_in_idle,
  input wire [`SPM_NPERIPH-1:0] periph_ext_clocked,
  input wire input_change_notify_event,
  output reg sys_clk_enable,
  output reg core_clk_enable,
  output reg onchip_osc_enable,
  output reg clock_failure_monitor_active,
  output reg low_power_rc_clock_enable,
  output reg watchdog_clear,
  output reg [`SPM_NPERIPH-1:0] periph_enable,
  output reg input_change_notify_enable,
  output reg main_regulator_standby,
  output reg flash_regulator_standby,
  output reg [2:0] active_clock_source,
  output reg core_halted,
  output reg in_sleep,
  output reg in_idle,
  output reg wake_resume,
  output reg wake_by_irq
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_RUN = 3'h0;
localparam ST_ENTER_SLEEP = 3'h1;
localparam ST_SLEEP = 3'h2;
localparam ST_ENTER_IDLE = 3'h3;
localparam ST_IDLE = 3'h4;
localparam ST_RESUME = 3'h5;

// ----------------------------------------
// timeout synchroniser
// ----------------------------------------
wire wdt_timeout_s;

spm_sync u_wdt_sync
(
  .clk(clk),
  .rstn(rstn),
  .d(watchdog_timeout),
  .q(wdt_timeout_s)
);

reg [2:0] state;
reg [2:0] next_state;
reg [2:0] resume_cnt;
reg [2:0] next_resume_cnt;
reg [2:0] entry_clock;
reg irq_deferred;
reg next_irq_deferred;
reg woke_irq;
reg next_woke_irq;

wire main_keep;
wire flash_keep;
wire [`SPM_NPERIPH-1:0] stop_vec;
wire wake_event;

assign main_keep = reset_control_register[`SPM_RESET_CONTROL_REGISTER_MAIN_KEEP_BIT];
assign flash_keep = reset_control_register[`SPM_RESET_CONTROL_REGISTER_FLASH_KEEP_BIT];
// (R16) timer one stop bit
assign stop_vec = {periph_stop_in_idle[`SPM_NPERIPH-1:1],
                   periph_stop_in_idle[0] | first_timer_control[`SPM_TIMER_SIDL_BIT]};
// (R6) sleep/idle wake sources
assign wake_event = irq_pending | wdt_timeout_s | irq_deferred;

// ----------------------------------------
// next-state logic
// ----------------------------------------
always @*
begin
  next_state = state;
  next_resume_cnt = resume_cnt;
  next_irq_deferred = irq_deferred;
  next_woke_irq = woke_irq;
  case (state)
    ST_RUN:
    begin
      // (R18) operand decode at retire
      if (power_save_retire)
      begin
        next_woke_irq = 1'b0;
        // (R17) hold coincident interrupt
        next_irq_deferred = irq_pending;
        if (power_save_operand == `SPM_OP_IDLE)
          next_state = ST_ENTER_IDLE;
        else
          next_state = ST_ENTER_SLEEP;
      end
    end
    ST_ENTER_SLEEP:
    begin
      next_irq_deferred = irq_deferred | irq_pending;
      next_state = ST_SLEEP;
    end
    ST_ENTER_IDLE:
    begin
      next_irq_deferred = irq_deferred | irq_pending;
      next_state = ST_IDLE;
    end
    ST_SLEEP, ST_IDLE:
    begin
      // (R14) exit on wake event
      if (wake_event)
      begin
        next_woke_irq = irq_pending | irq_deferred;
        next_irq_deferred = 1'b0;
        next_resume_cnt = `SPM_RESUME_CYC;
        next_state = ST_RESUME;
      end
    end
    ST_RESUME:
    begin
      // (R15) resume delay count
      if (resume_cnt <= 3'h1)
        next_state = ST_RUN;
      else
        next_resume_cnt = resume_cnt - 3'h1;
    end
    default:
      next_state = ST_RUN;
  endcase
end

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    state <= ST_RUN;
    resume_cnt <= 3'h0;
    irq_deferred <= 1'b0;
    woke_irq <= 1'b0;
    entry_clock <= 3'h0;
  end
  else
  begin
    state <= next_state;
    resume_cnt <= next_resume_cnt;
    irq_deferred <= next_irq_deferred;
    woke_irq <= next_woke_irq;
    // (R7) latch clock at entry
    if (state == ST_RUN && power_save_retire)
      entry_clock <= clock_source_select;
  end
end

// ----------------------------------------
// registered outputs
// ----------------------------------------
wire sleep_ns;
wire idle_ns;
wire halt_ns;
wire entering_ns;

assign sleep_ns = (next_state == ST_SLEEP);
assign idle_ns = (next_state == ST_IDLE);
assign entering_ns = (next_state == ST_ENTER_SLEEP) || (next_state == ST_ENTER_IDLE);
assign halt_ns = (next_state != ST_RUN);

genvar gi;
generate
  for (gi = 0; gi < `SPM_NPERIPH; gi = gi + 1)
  begin : g_periph
    always @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        periph_enable[gi] <= 1'b1;
      // (R5) sleep gating
      else if (sleep_ns)
        periph_enable[gi] <= periph_ext_clocked[gi];
      // (R12) selective idle stop
      else if (idle_ns)
        periph_enable[gi] <= ~stop_vec[gi];
      else
        periph_enable[gi] <= 1'b1;
    end
  end
endgenerate

// ----------------------------------------
// clock and oscillator gating
// ----------------------------------------
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    sys_clk_enable <= 1'b1;
    core_clk_enable <= 1'b1;
    onchip_osc_enable <= 1'b1;
    clock_failure_monitor_active <= 1'b0;
    low_power_rc_clock_enable <= 1'b0;
    core_halted <= 1'b0;
  end
  else
  begin
    // (R1) stop system clock in sleep
    sys_clk_enable <= ~sleep_ns;
    onchip_osc_enable <= ~(sleep_ns & onchip_osc_selected);
    // (R10) halt core clock
    core_clk_enable <= ~halt_ns;
    core_halted <= halt_ns;
    // (R2) monitor off in sleep
    clock_failure_monitor_active <= clock_failure_monitor_enable & ~sleep_ns;
    // (R3) rc clock in sleep
    // (R13) rc clock in idle
    if (sleep_ns)
      low_power_rc_clock_enable <= watchdog_timer_enable;
    else
      low_power_rc_clock_enable <= watchdog_timer_enable | clock_failure_monitor_enable;
  end
end

// ----------------------------------------
// watchdog, change-notify and regulators
// ----------------------------------------
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    watchdog_clear <= 1'b0;
    input_change_notify_enable <= 1'b1;
    main_regulator_standby <= 1'b0;
    flash_regulator_standby <= 1'b0;
  end
  else
  begin
    // (R4) clear watchdog on entry
    // (R11) also for idle entry
    watchdog_clear <= entering_ns & watchdog_timer_enable;
    input_change_notify_enable <= 1'b1;
    // (R8) regulator standby in sleep
    // (R9) keep-active override
    main_regulator_standby <= sleep_ns & ~main_keep;
    flash_regulator_standby <= sleep_ns & ~flash_keep;
  end
end

// ----------------------------------------
// clock source and status flags
// ----------------------------------------
wire resume_done;

assign resume_done = (state == ST_RESUME) && (next_state == ST_RUN);

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    active_clock_source <= 3'h0;
    in_sleep <= 1'b0;
    in_idle <= 1'b0;
    wake_resume <= 1'b0;
    wake_by_irq <= 1'b0;
  end
  else
  begin
    // (R7) entry clock held until run
    if (state == ST_RUN)
      active_clock_source <= clock_source_select;
    else
      active_clock_source <= entry_clock;
    in_sleep <= sleep_ns;
    in_idle <= idle_ns;
    // (R15) resume pulse
    wake_resume <= resume_done;
    wake_by_irq <= resume_done & woke_irq;
  end
end

endmodule // spm_power_manager

/* File: spm_consts.vh */
// constants for the sleep/idle power manager
// assumes a 200 MHz system clock and a 16-bit control register view
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// ----------------------------------------
// reset control register bit positions
// ----------------------------------------
`define SPM_RESET_CONTROL_REGISTER_MAIN_KEEP_BIT 8
`define SPM_RESET_CONTROL_REGISTER_FLASH_KEEP_BIT 11
`define SPM_RESET_CONTROL_REGISTER_RESET 16'h0000

// ----------------------------------------
// first timer control stop-in-idle bit
// ----------------------------------------
`define SPM_TIMER_SIDL_BIT 13

// ----------------------------------------
// power-save operand encoding
// ----------------------------------------
`define SPM_OP_SLEEP 1'h0
`define SPM_OP_IDLE 1'h1

// ----------------------------------------
// restart timing, in clock cycles
// ----------------------------------------
`define SPM_RESUME_MIN 2
`define SPM_RESUME_MAX 4
`define SPM_RESUME_CYC 3'h3

// ----------------------------------------
// width of peripheral enable vectors
// ----------------------------------------
`define SPM_NPERIPH 8

`endif

/* File: spm_sync.v */
// two-flop synchroniser for one level
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module spm_sync
(
  input wire clk,
  input wire rstn,
  input wire d,
  output reg q
);

reg meta;

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    meta <= 1'b0;
    q <= 1'b0;
  end
  else
  begin
    meta <= d;
    q <= meta;
  end
end

endmodule // spm_sync

/* File: spm_power_manager_asserts.sv */
// port-level checks for the sleep and idle power manager
// assumes binding onto spm_power_manager with its inputs driven by a core model
`timescale 1ns/1ps
`include "spm_consts.vh"
module spm_power_manager_asserts
(
  input wire clk, rstn, power_save_retire, power_save_operand, irq_pending,
  input wire watchdog_timer_enable, clock_failure_monitor_enable, onchip_osc_selected,
  input wire [15:0] reset_control_register, first_timer_control,
  input wire [`SPM_NPERIPH-1:0] periph_stop_in_idle, periph_ext_clocked, periph_enable,
  input wire sys_clk_enable, core_clk_enable, onchip_osc_enable, clock_failure_monitor_active,
  input wire low_power_rc_clock_enable, watchdog_clear, main_regulator_standby,
  input wire flash_regulator_standby, core_halted, in_sleep, in_idle, wake_resume,
  input wire [2:0] active_clock_source
);
  // ----------------------------------------
  // entry, gating and wake relations
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_take;
    power_save_retire && core_clk_enable;
  endsequence
  sequence s_wake;
    (in_sleep || in_idle) && irq_pending;
  endsequence
  AST_SLEEP_ENTRY: assert property (s_take ##0 !power_save_operand |-> ##2 in_sleep)
    else $error("sleep not entered two cycles after retire");
  AST_IDLE_ENTRY: assert property (s_take ##0 power_save_operand |-> ##2 in_idle)
    else $error("idle not entered two cycles after retire");
  AST_WDT_CLEAR: assert property (s_take ##0 watchdog_timer_enable |=> watchdog_clear)
    else $error("watchdog not cleared on entry");
  AST_SLEEP_CLK: assert property (in_sleep |-> !sys_clk_enable
    && !clock_failure_monitor_active && !($past(onchip_osc_selected) && onchip_osc_enable))
    else $error("clock still running in sleep");
  AST_LOW_POWER_RC_CLOCK: assert property (
    (in_sleep |-> low_power_rc_clock_enable == $past(watchdog_timer_enable))
    and (in_idle |-> low_power_rc_clock_enable ==
    $past(watchdog_timer_enable || clock_failure_monitor_enable)))
    else $error("low-power clock enable wrong");
  AST_REGULATOR: assert property (in_sleep |->
    main_regulator_standby == !$past(reset_control_register[`SPM_RESET_CONTROL_REGISTER_MAIN_KEEP_BIT])
    && flash_regulator_standby == !$past(reset_control_register[`SPM_RESET_CONTROL_REGISTER_FLASH_KEEP_BIT]))
    else $error("regulator standby wrong in sleep");
  AST_SLEEP_PERIPH: assert property (in_sleep |-> periph_enable == $past(periph_ext_clocked))
    else $error("peripheral enables wrong in sleep");
  AST_IDLE_PERIPH: assert property (in_idle |-> sys_clk_enable && periph_enable ==
    ~$past(periph_stop_in_idle | {7'h00, first_timer_control[`SPM_TIMER_SIDL_BIT]}))
    else $error("peripheral enables wrong in idle");
  AST_WAKE: assert property (s_wake |=>
    !in_sleep && !in_idle ##3 wake_resume && core_clk_enable)
    else $error("wake did not resume in four cycles");
  AST_HALT: assert property ((in_sleep || in_idle) |-> core_halted && !core_clk_enable)
    else $error("core not halted");
  AST_CLK_SOURCE: assert property (!core_clk_enable && !$past(core_clk_enable)
    |-> $stable(active_clock_source))
    else $error("clock source changed while halted");
endmodule // spm_power_manager_asserts

bind spm_power_manager spm_power_manager_asserts spm_power_manager_asserts_inst (.*);

/* File: spm_core_model.sv */
// processor core model issuing the power-save retire pulse
// assumes req is a one-cycle command from the testbench
`timescale 1ns/1ps
module spm_core_model
(
  input wire clk, rstn, req, req_op, wake_resume,
  output reg power_save_retire, power_save_operand
);
  reg waiting;
  always @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      power_save_retire <= 1'b0;
      power_save_operand <= 1'b0;
      waiting <= 1'b0;
    end
    else
    begin
      power_save_retire <= req && !waiting;
      power_save_operand <= (req && !waiting) ? req_op : ~power_save_operand;
      waiting <= (waiting || req) && !wake_resume;
    end
endmodule // spm_core_model

/* File: spm_power_manager_tb.sv */
// self-checking bench for the sleep and idle power manager
// assumes 200 MHz clock and a core model giving the retire pulse
`timescale 1ns/1ps
`include "spm_consts.vh"
module spm_power_manager_tb;
  logic clk = 0, rstn = 0, req = 0, req_op = 0, irq_pending = 0, watchdog_timeout = 0;
  logic watchdog_timer_enable = 1, clock_failure_monitor_enable = 1, onchip_osc_selected = 1;
  logic input_change_notify_event = 0, power_save_retire, power_save_operand;
  logic [2:0] clock_source_select = 3'h5, active_clock_source;
  logic [15:0] reset_control_register = 16'h0000, first_timer_control = 16'h0000;
  logic [`SPM_NPERIPH-1:0] periph_stop_in_idle = 8'h00, periph_ext_clocked = 8'h0C;
  logic [`SPM_NPERIPH-1:0] periph_enable;
  logic sys_clk_enable, core_clk_enable, onchip_osc_enable, clock_failure_monitor_active;
  logic low_power_rc_clock_enable, watchdog_clear, input_change_notify_enable, in_idle;
  logic main_regulator_standby, flash_regulator_standby, core_halted, in_sleep;
  logic wake_resume, wake_by_irq;
  int n_mismatch = 0, num_checks = 0, n;
  always #2.5 clk = ~clk;
  spm_power_manager spm_power_manager_inst (.*);
  spm_core_model spm_core_model_inst (.clk, .rstn, .req, .req_op, .wake_resume,
    .power_save_retire, .power_save_operand);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task enter(input logic op);
    @(posedge clk) begin req <= 1; req_op <= op; end
    @(posedge clk) req <= 0;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (in_sleep !== 1 && in_idle !== 1 && n < 20);
    chk("entered", in_sleep | in_idle, 1);
  endtask
  task wake(input logic by_irq);
    @(posedge clk) if (by_irq) irq_pending <= 1; else watchdog_timeout <= 1;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (wake_resume !== 1 && n < 20);
    chk("wake seen", wake_resume, 1);
    chk("wake_by_irq", wake_by_irq, by_irq);
    chk("core_clk", core_clk_enable, 1);
    @(posedge clk) begin irq_pending <= 0; watchdog_timeout <= 0; end
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin #20000; n_mismatch++; give_verdict; end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    chk("reset periph", periph_enable, 8'hFF);
    rstn <= 1;
    enter(`SPM_OP_SLEEP);
    @(posedge clk) clock_source_select <= 3'h2;
    #1 chk("in_sleep", in_sleep, 1);
    chk("osc", onchip_osc_enable, 0);
    chk("monitor", clock_failure_monitor_active, 0);
    chk("low_power_rc_clock", low_power_rc_clock_enable, 1);
    chk("standby", {main_regulator_standby, flash_regulator_standby}, 2'h3);
    chk("periph", periph_enable, 8'h0C);
    chk("source", active_clock_source, 3'h5);
    chk("sysclk", sys_clk_enable, 0);
    chk("icn", input_change_notify_enable, 1);
    wake(1);
    reset_control_register <= 16'h0900;
    enter(`SPM_OP_SLEEP);
    chk("keep", {main_regulator_standby, flash_regulator_standby}, 2'h0);
    wake(0);
    watchdog_timer_enable <= 0;
    periph_stop_in_idle <= 8'h30;
    first_timer_control <= 16'h2000;
    enter(`SPM_OP_IDLE);
    chk("idle periph", periph_enable, 8'hCE);
    chk("idle low_power_rc_clock", low_power_rc_clock_enable, 1);
    chk("halted", {core_halted, sys_clk_enable}, 2'h3);
    wake(1);
    chk("resume", (n - 1 >= `SPM_RESUME_MIN) && (n - 1 <= `SPM_RESUME_MAX), 1);
    fork
      enter(`SPM_OP_SLEEP);
      begin
        repeat (2) @(posedge clk);
        irq_pending <= 1;
        @(posedge clk) irq_pending <= 0;
      end
    join
    chk("deferred", in_sleep, 1);
    n = 0;
    do begin @(posedge clk); #1; n++; end while (wake_resume !== 1 && n < 20);
    chk("deferred wake", n, 4);
    chk("deferred irq", wake_by_irq, 1);
    enter(`SPM_OP_SLEEP);
    @(posedge clk) rstn <= 0;
    #1 chk("reset wake", {in_sleep, sys_clk_enable}, 2'h1);
    give_verdict;
  end
endmodule // spm_power_manager_tb
